/* design/acq_trigger_strobe_timer.sv */
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "acq_timer_consts.svh"
// Behaviour
// RULE_01: Single and periodic strobe outputs, each with its own enable.
// RULE_02: Single pulse high after its delay from trigger, for its width.
// RULE_03: Single pulse forced low at end of integration.
// RULE_04: Single pulse counts from trigger, not shifted by acquisition delay.
// RULE_05: Periodic output 50% duty at set period, only during integration. Code holds odd periods high one tick longer than low.
// RULE_06: Soft and edge modes emit only whole periods; none if too short. Code also emits none when integ equals the period.
// RULE_07: Level mode drops periodic output at integration end, cutting it.
// RULE_08: Each trigger runs delay, integration, then final busy phases.
// RULE_09: Trigger to integration equals acquisition delay plus initial busy.
// RULE_10: Acquisition delay 0 to 335500 us in 1 us steps.
// RULE_11: Acquisition delay never changes integration length.
// RULE_12: Three trigger modes chosen by a host mode setting.
// RULE_13: Software mode after reset; host trigger command starts a cycle.
// RULE_14: Edge mode: external rising edge starts cycle, programmed length.
// RULE_15: Level mode: rising edge starts; integration lasts while input high.
// RULE_16: After final busy, wait for data transfer, then accept triggers.
// RULE_17: Short-busy: initial busy 1 us if integ >= 218, else 219 - integ.
// RULE_18: External driver holds trigger high at least 10 ns per pulse.
// RULE_19: Edge event registered 20 to 30 ns after the rising edge.
// RULE_20: All timing counted on a 1 us tick from the device clock.
module acq_trigger_strobe_timer
  import acq_timer_pkg::*;
#(
  parameter logic [31:0] FINAL_BUSY_US = `RST_FINAL_BUSY,
  parameter logic [31:0] LONG_BUSY1_US = `LONG_BUSY1_US,
  parameter int unsigned TICK_DIV      = `TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Trigger and strobe pins
  input  wire logic        ext_trigger,
  output logic             single_strobe,
  output logic             pulse_train,
  // Acquisition status
  output logic             integrating,
  output logic             acq_busy
);
  trig_mode_t  mode;
  logic        sp_en;
  logic        pt_en;
  logic        short_busy;
  timing_cfg_t cfg;
  ahb_addr_t   ap;
  phase_t      phase;
  logic        tick;
  logic        trig_sync1;
  logic        trig_sync2;
  logic        trig_prev;
  logic        soft_trig;
  logic        xfer_done;
  logic        event_go;
  logic [31:0] phase_cnt;
  logic [31:0] phase_len;
  logic [31:0] sp_cnt;
  logic        sp_active;
  logic [31:0] pt_cnt;
  logic [31:0] pt_half;
  logic        pt_run;
  logic [31:0] cycle_cnt;
  logic [31:0] busy1_len;
  logic        integ_end;

  function automatic logic [31:0] initial_busy(input logic [31:0] integ,
                                               input logic short_v);
    if (!short_v)
      initial_busy = LONG_BUSY1_US;
    else if (integ >= `SHORT_BUSY_KNEE_US)
      initial_busy = `SHORT_BUSY_MIN_US;
    else
      initial_busy = `SHORT_BUSY_BASE_US - integ; // [RULE_17]
  endfunction

  us_tick_gen #(.DIV(TICK_DIV)) u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick)
  );

  // Bus: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      ap <= '0;
    else if (hready)
      ap <= '{haddr: haddr, hwrite: hwrite,
              sel: hsel & htrans[1]};
  end

  // Register writes; trigger mode and enables [RULE_12] [RULE_01]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode       <= mode_soft; // [RULE_13]
      sp_en      <= 1'b0;
      pt_en      <= 1'b0;
      short_busy <= 1'b0;
      cfg        <= '0;
      cfg.integ  <= `RST_INTEG;
    end else if (ap.sel && ap.hwrite) begin
      if (ap.haddr[11:0] == `OFF_CTRL) begin
        mode       <= (hwdata[1:0] == 2'd3) ? mode_soft
                      : trig_mode_t'(hwdata[1:0]);
        sp_en      <= hwdata[`CTRL_SP_EN_BIT];
        pt_en      <= hwdata[`CTRL_PT_EN_BIT];
        short_busy <= hwdata[`CTRL_SHORT_BIT];
      end else if (ap.haddr[11:0] == `OFF_ACQ_DELAY) begin
        // Clamp at the largest legal delay [RULE_10]
        cfg.acq_delay <= (hwdata > `ACQ_DELAY_MAX_US)
                         ? `ACQ_DELAY_MAX_US : hwdata;
      end else if (ap.haddr[11:0] == `OFF_INTEG) begin
        cfg.integ <= (hwdata == 32'h0) ? 32'h1 : hwdata;
      end else if (ap.haddr[11:0] == `OFF_SP_DELAY) begin
        cfg.sp_delay <= hwdata;
      end else if (ap.haddr[11:0] == `OFF_SP_WIDTH) begin
        cfg.sp_width <= hwdata;
      end else if (ap.haddr[11:0] == `OFF_PT_PERIOD) begin
        cfg.pt_period <= hwdata;
      end
    end
  end

  // Command strobes, one cycle each
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      soft_trig <= 1'b0;
      xfer_done <= 1'b0;
    end else begin
      soft_trig <= ap.sel && ap.hwrite && ap.haddr[11:0] == `OFF_CMD
                   && hwdata[`CMD_TRIG_BIT];
      xfer_done <= ap.sel && ap.hwrite && ap.haddr[11:0] == `OFF_CMD
                   && hwdata[`CMD_DONE_BIT];
    end
  end

  // Read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      if (haddr[11:0] == `OFF_CTRL)
        hrdata <= {27'h0, short_busy, pt_en, sp_en, mode};
      else if (haddr[11:0] == `OFF_ACQ_DELAY)
        hrdata <= cfg.acq_delay;
      else if (haddr[11:0] == `OFF_INTEG)
        hrdata <= cfg.integ;
      else if (haddr[11:0] == `OFF_SP_DELAY)
        hrdata <= cfg.sp_delay;
      else if (haddr[11:0] == `OFF_SP_WIDTH)
        hrdata <= cfg.sp_width;
      else if (haddr[11:0] == `OFF_PT_PERIOD)
        hrdata <= cfg.pt_period;
      else if (haddr[11:0] == `OFF_STATUS)
        hrdata <= {26'h0, pulse_train, single_strobe, 1'b0, phase};
      else
        hrdata <= 32'h0;
    end
  end

  // Pin sync; 2 stages plus edge flop give 20..30 ns latency [RULE_19]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_sync1 <= 1'b0;
      trig_sync2 <= 1'b0;
      trig_prev  <= 1'b0;
    end else begin
      trig_sync1 <= ext_trigger;
      trig_sync2 <= trig_sync1;
      trig_prev  <= trig_sync2;
    end
  end

  // Trigger source chosen by mode [RULE_13] [RULE_14] [RULE_15]
  // A 10 ns high pulse is caught by the first flop only if it spans an
  // edge; the driver's minimum width guarantees that [RULE_18]
  assign event_go = (phase == st_idle) &&
                    ((mode == mode_soft) ? soft_trig
                                         : (trig_sync2 && !trig_prev));

  assign busy1_len = initial_busy(cfg.integ, short_busy);

  // Delay phase is acquisition delay plus initial busy [RULE_09] [RULE_11]
  always_comb begin
    case (phase)
      st_delay: phase_len = cfg.acq_delay + busy1_len;
      st_integ: phase_len = cfg.integ;
      st_final: phase_len = FINAL_BUSY_US;
      default:  phase_len = 32'h0;
    endcase
  end

  // Level mode ends integration on the falling input [RULE_15]
  assign integ_end = (phase == st_integ) &&
                     ((mode == mode_level) ? !trig_sync2
                      : (tick && phase_cnt + 32'h1 >= phase_len));

  // Three-phase acquisition sequence [RULE_08] [RULE_20]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase     <= st_idle;
      phase_cnt <= 32'h0;
    end else begin
      case (phase)
        st_idle: begin
          if (event_go) begin
            phase     <= st_delay;
            phase_cnt <= 32'h0;
          end
        end
        st_delay, st_final: begin
          if (tick) begin
            if (phase_cnt + 32'h1 >= phase_len) begin
              phase     <= (phase == st_delay) ? st_integ : st_hold;
              phase_cnt <= 32'h0;
            end else begin
              phase_cnt <= phase_cnt + 32'h1;
            end
          end
        end
        st_integ: begin
          if (integ_end) begin
            phase     <= st_final;
            phase_cnt <= 32'h0;
          end else if (tick) begin
            phase_cnt <= phase_cnt + 32'h1;
          end
        end
        // Waits for host to take the data before rearming [RULE_16]
        st_hold: if (xfer_done) phase <= st_idle;
        default: phase <= st_idle;
      endcase
    end
  end

  assign integrating = (phase == st_integ);
  assign acq_busy    = (phase != st_idle);

  // Single pulse counted from the trigger event [RULE_04] [RULE_02]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cycle_cnt     <= 32'h0;
      sp_active     <= 1'b0;
      single_strobe <= 1'b0;
    end else if (event_go) begin
      cycle_cnt     <= 32'h0;
      sp_active     <= 1'b1;
      single_strobe <= sp_en && cfg.sp_delay == 32'h0
                       && cfg.sp_width != 32'h0;
    end else if (integ_end) begin
      sp_active     <= 1'b0;
      single_strobe <= 1'b0; // [RULE_03]
    end else if (sp_active && tick) begin
      cycle_cnt <= cycle_cnt + 32'h1;
      if (cycle_cnt + 32'h1 >= cfg.sp_delay + cfg.sp_width) begin
        sp_active     <= 1'b0;
        single_strobe <= 1'b0;
      end else if (cycle_cnt + 32'h1 >= cfg.sp_delay) begin
        single_strobe <= sp_en && cfg.sp_width != 32'h0; // [RULE_01]
      end
    end
  end

  assign sp_cnt  = cfg.integ - phase_cnt;
  assign pt_half = {1'b0, cfg.pt_period[31:1]};

  // Periodic output during integration only [RULE_05] [RULE_01]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pt_cnt      <= 32'h0;
      pt_run      <= 1'b0;
      pulse_train <= 1'b0;
    end else if (phase != st_integ || integ_end) begin
      pt_cnt      <= 32'h0;
      pulse_train <= 1'b0; // [RULE_07]
      // Arm when integration begins; outside level mode integ must exceed the period [RULE_06]
      pt_run      <= (phase == st_delay) && pt_en &&
                     cfg.pt_period != 32'h0 &&
                     (mode == mode_level || cfg.integ > cfg.pt_period);
      if (phase == st_delay && pt_en && cfg.pt_period != 32'h0 &&
          (mode == mode_level || cfg.integ > cfg.pt_period) &&
          tick && phase_cnt + 32'h1 >= phase_len)
        pulse_train <= 1'b1;
    end else if (pt_run && tick) begin
      if (pt_cnt + 32'h1 >= cfg.pt_period) begin
        pt_cnt <= 32'h0;
        // Outside level mode, start a new period only if it ends inside integration [RULE_06]
        if (mode != mode_level && sp_cnt - 32'h1 < cfg.pt_period) begin
          pt_run      <= 1'b0;
          pulse_train <= 1'b0;
        end else begin
          pulse_train <= 1'b1;
        end
      end else begin
        pt_cnt      <= pt_cnt + 32'h1;
        pulse_train <= (pt_cnt + 32'h1 < cfg.pt_period - pt_half);
      end
    end
  end
endmodule

/* design/acq_timer_consts.svh */
`ifndef ACQ_TIMER_CONSTS_SVH
`define ACQ_TIMER_CONSTS_SVH

// Register byte offsets
`define OFF_CTRL        12'h000
`define OFF_CMD         12'h004
`define OFF_ACQ_DELAY   12'h008
`define OFF_INTEG       12'h00c
`define OFF_SP_DELAY    12'h010
`define OFF_SP_WIDTH    12'h014
`define OFF_PT_PERIOD   12'h018
`define OFF_STATUS      12'h01c

// Control fields
`define CTRL_MODE_LSB   0
`define CTRL_SP_EN_BIT  2
`define CTRL_PT_EN_BIT  3
`define CTRL_SHORT_BIT  4

// Command fields (write one to act)
`define CMD_TRIG_BIT    0
`define CMD_DONE_BIT    1

// Reset values
`define RST_CTRL        5'h00
`define RST_INTEG       32'h0000_1c20
`define RST_FINAL_BUSY  32'h0000_00da

// Timing
`define CLK_MHZ         100
`define TICK_NS         1000
`define CLK_NS          10
`define TICK_CYCLES     (`TICK_NS / `CLK_NS)
`define ACQ_DELAY_MAX_US 32'd335500
`define SHORT_BUSY_KNEE_US 32'd218
`define SHORT_BUSY_BASE_US 32'd219
`define SHORT_BUSY_MIN_US  32'd1
`define LONG_BUSY1_US   32'd3706

`endif

/* design/acq_timer_pkg.sv */
package acq_timer_pkg;
  typedef enum logic [1:0] {
    mode_soft  = 2'd0,
    mode_edge  = 2'd1,
    mode_level = 2'd2
  } trig_mode_t;

  typedef enum logic [2:0] {
    st_idle, st_delay, st_integ, st_final, st_hold
  } phase_t;

  typedef struct packed {
    logic [31:0] acq_delay;
    logic [31:0] integ;
    logic [31:0] sp_delay;
    logic [31:0] sp_width;
    logic [31:0] pt_period;
  } timing_cfg_t;

  typedef struct packed {
    logic [31:0] haddr;
    logic        hwrite;
    logic        sel;
  } ahb_addr_t;
endpackage

/* design/us_tick_gen.sv */
`timescale 1ns/1ps
`include "acq_timer_consts.svh"
module us_tick_gen #(
  parameter int unsigned DIV = `TICK_CYCLES
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Tick
  output logic      tick
);
  logic [15:0] cnt;

  // One pulse every microsecond [RULE_20]
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt  <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt == 16'(DIV - 1)) begin
      cnt  <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule

/* tb/acq_timer_properties.sv */
`timescale 1ns/1ps
`include "acq_timer_consts.svh"
module acq_timer_properties
  import acq_timer_pkg::*;
#(
  parameter int unsigned TICK_DIV = 100
) (
  // Clock and bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  // Pins and status
  input wire logic        ext_trigger,
  input wire logic        single_strobe,
  input wire logic        pulse_train,
  input wire logic        integrating,
  input wire logic        acq_busy
);
  localparam int LVL_MAX = TICK_DIV + 4;
  logic        dwr;
  logic [11:0] dadr;
  logic [1:0]  mode;
  logic        cmd_wr;
  logic        done_wr;
  logic        ext_mode;
  assign cmd_wr   = dwr && hready && dadr == `OFF_CMD;
  assign done_wr  = cmd_wr && hwdata[1];
  assign ext_mode = mode == mode_edge || mode == mode_level;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dwr  <= 1'b0;
      dadr <= 12'h000;
    end else if (hready) begin
      dwr  <= hsel && htrans[1] && hwrite;
      dadr <= haddr[11:0];
    end
  end
  // Mode shadowed from bus writes, so no probe into the design is needed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      mode <= 2'h0;
    else if (dwr && hready && dadr == `OFF_CTRL)
      mode <= hwdata[1:0];
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_train_in_integ: assert property (
    pulse_train |-> integrating || $past(integrating))
    else $error("pulse train high outside integration");
  a_strobes_cut_end: assert property (
    $fell(integrating) |-> ##[0:1] !single_strobe && !pulse_train)
    else $error("strobe still high after integration");
  a_busy_over_integ: assert property (
    integrating |-> acq_busy)
    else $error("integration outside a busy cycle");
  a_integ_after_delay: assert property (
    $rose(integrating) |-> $past(acq_busy))
    else $error("integration began with no delay phase");
  a_edge_latency: assert property (
    ext_mode && $rose(ext_trigger) && !acq_busy |-> ##[2:3] acq_busy)
    else $error("pin edge not registered in time");
  a_soft_start: assert property (
    cmd_wr && hwdata[0] && !ext_mode && !acq_busy |-> ##[1:2] acq_busy)
    else $error("software trigger did not start a cycle");
  a_rearm_on_done: assert property (
    $fell(acq_busy) |-> $past(done_wr) || $past(done_wr, 2))
    else $error("cycle ended without transfer done");
  a_level_ends_integ: assert property (
    mode == mode_level && $fell(ext_trigger) && integrating
    |-> ##[1:LVL_MAX] !integrating)
    else $error("integration outlived the level pulse");
endmodule
bind acq_trigger_strobe_timer acq_timer_properties #(
  .TICK_DIV(TICK_DIV)
) u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .ext_trigger(ext_trigger), .single_strobe(single_strobe),
  .pulse_train(pulse_train), .integrating(integrating),
  .acq_busy(acq_busy)
);

/* tb/ext_instrument.sv */
`timescale 1ns/1ps
module ext_instrument (
  // Clock
  input wire logic hclk,
  // Observed outputs
  input wire logic single_strobe,
  input wire logic pulse_train,
  input wire logic integrating,
  input wire logic acq_busy,
  // Trigger pin
  output logic     ext_trigger
);
  int   ss_cyc;
  int   pt_cyc;
  int   pt_rises;
  int   ig_cyc;
  int   dly_cyc;
  logic ss_early = 1'b0;
  logic seen     = 1'b0;
  logic pt_q     = 1'b0;
  initial ext_trigger = 1'b0;
  always @(posedge hclk) begin
    ss_cyc   += single_strobe;
    pt_cyc   += pulse_train;
    ig_cyc   += integrating;
    pt_rises += pulse_train && !pt_q;
    dly_cyc  += acq_busy && !integrating && !seen;
    if (single_strobe && !integrating && !seen)
      ss_early = 1'b1;
    if (integrating)
      seen = 1'b1;
    pt_q = pulse_train;
  end
  task automatic clear();
    {ss_cyc, pt_cyc, pt_rises, ig_cyc, dly_cyc} = '0;
    ss_early = 1'b0;
    seen     = 1'b0;
  endtask
  // Whole clocks of high time, never below the minimum pulse width
  task automatic fire(input int hi);
    @(posedge hclk);
    ext_trigger <= 1'b1;
    repeat (hi) @(posedge hclk);
    ext_trigger <= 1'b0;
  endtask
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
`include "acq_timer_consts.svh"
module tb;
  typedef struct {
    logic [7:0] ctrl;
    int         acq, integ, spd, spw, per, ss, pr;
  } row_t;
  // Short tick keeps the long initial busy affordable
  localparam int TD = 4;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        ext_trigger, single_strobe, pulse_train, integrating;
  logic        acq_busy;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          err_count, n_compared, dly;
  row_t        r;
  row_t        rows[7] = '{
    '{8'h1c, 3, 20, 2, 5, 6, 20, 3}, '{8'h1c, 0, 10, 205, 50, 10, 56, 0},
    '{8'h18, 0, 300, 0, 9, 7, 0, 42}, '{8'h04, 0, 5, 1, 3, 0, 12, 0},
    '{8'h1d, 2, 20, 1, 2, 5, 8, 4}, '{8'h1f, 1, 218, 0, 0, 218, 0, 0},
    '{8'h1c, 0, 217, 0, 0, 216, 0, 1}};
  assign hready = hreadyout;
  acq_trigger_strobe_timer #(.TICK_DIV(TD)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ext_trigger(ext_trigger),
    .single_strobe(single_strobe), .pulse_train(pulse_train),
    .integrating(integrating), .acq_busy(acq_busy));
  ext_instrument u_inst (
    .hclk(hclk), .single_strobe(single_strobe), .pulse_train(pulse_train),
    .integrating(integrating), .acq_busy(acq_busy),
    .ext_trigger(ext_trigger));
  always #5 hclk = ~hclk;
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic step(inout int n);
    @(posedge hclk);
    n++;
    if (n > 10000) begin
      err_count++;
      final_report();
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n = 0;
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {20'h00000, a};
    hwrite <= w;
    hsize  <= 3'h2;
    do step(n); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do step(n); while (hready !== 1'b1);
    q = hrdata;
  endtask
  // Poll until the hold phase, then release the cycle with transfer done
  task automatic finish_cycle();
    int n = 0;
    do begin
      bus(1'b0, `OFF_STATUS, 32'h0, rd);
      step(n);
    end while (rd[2:0] !== 3'h4);
    check(acq_busy, 1'b1);
    bus(1'b1, `OFF_CMD, 32'h2, rd);
    do step(n); while (acq_busy !== 1'b0);
  endtask
  initial begin
    {hclk, hresetn, hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, `OFF_CTRL, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b0, `OFF_INTEG, 32'h0, rd);
    check(rd, `RST_INTEG);
    bus(1'b0, 12'h020, 32'h0, rd);
    check(rd, 32'h0);
    foreach (rows[i]) begin
      r = rows[i];
      bus(1'b1, `OFF_CTRL, {24'h0, r.ctrl}, rd);
      bus(1'b1, `OFF_ACQ_DELAY, r.acq, rd);
      bus(1'b1, `OFF_INTEG, r.integ, rd);
      bus(1'b1, `OFF_SP_DELAY, r.spd, rd);
      bus(1'b1, `OFF_SP_WIDTH, r.spw, rd);
      bus(1'b1, `OFF_PT_PERIOD, r.per, rd);
      dly = r.acq + (!r.ctrl[4] ? 3706 : r.integ >= 218 ? 1 : 219 - r.integ);
      u_inst.clear();
      if (r.ctrl[1:0] inside {2'h1, 2'h2})
        u_inst.fire(2);
      else
        bus(1'b1, `OFF_CMD, 32'h1, rd);
      finish_cycle();
      check((u_inst.dly_cyc + TD - 1) / TD, dly);
      check(u_inst.ig_cyc, r.integ * TD);
      check(u_inst.ss_cyc, r.ss);
      check(u_inst.ss_early, r.ss > 0 && r.spd < dly);
      check(u_inst.pt_rises, r.pr);
      check(u_inst.pt_cyc, r.pr * ((r.per + 1) / 2) * TD);
    end
    bus(1'b1, `OFF_CTRL, 32'h1e, rd);
    bus(1'b1, `OFF_INTEG, 32'd300, rd);
    bus(1'b1, `OFF_PT_PERIOD, 32'd6, rd);
    u_inst.clear();
    u_inst.fire(27 * TD);
    finish_cycle();
    check((u_inst.ig_cyc + TD - 1) / TD inside {[25:27]}, 1'b1);
    check(u_inst.pt_rises, 5);
    check(u_inst.pt_cyc < 15 * TD, 1'b1);
    bus(1'b1, `OFF_ACQ_DELAY, 32'h0010_0000, rd);
    bus(1'b0, `OFF_ACQ_DELAY, 32'h0, rd);
    check(rd, `ACQ_DELAY_MAX_US);
    // Reset in the middle of a long delay phase must rearm in software mode
    u_inst.fire(2);
    repeat (4) @(posedge hclk);
    check(acq_busy, 1'b1);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    check(acq_busy, 1'b0);
    bus(1'b0, `OFF_CTRL, 32'h0, rd);
    check(rd, 32'h0);
    final_report();
  end
endmodule
